// [updir_upper_direction.sv]
// Upper pin direction register with pin output-enable steering
`timescale 1ns/1ps

module updir_upper_direction
    import updir_pkg::*;
(
    // Clock and control
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // Configuration space access
    input  wire logic [11:0] cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wide,
    input  wire logic [31:0] cfg_wdata,
    output logic      [15:0] cfg_rdata,
    output logic             cfg_rdata_valid,
    // Request to the lower direction register (first half of a wide access)
    output logic             lower_dir_wr,
    output logic             lower_dir_rd,
    output logic      [15:0] lower_dir_wdata,
    // Neighbour register contents
    input  wire logic [15:0] upper_function_select_register,
    input  wire logic [15:0] pin_data,
    // Dedicated interface function
    input  wire logic [15:0] func_out,
    input  wire logic [15:0] func_oe,
    // Pin pads 16 to 31
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe
);

    // ==========================================================
    // Access decode
    logic [15:0]     upper_direction_register_ff;
    logic [15:0]     nxt_upper_direction_register;
    updir_split_type split_ff;
    logic [15:0]     split_wdata_ff;
    logic            split_wr_ff;
    logic            hit_upper;
    logic            hit_wide;
    logic            upper_wr_now;
    logic            upper_rd_now;

    assign hit_upper = cfg_addr == UPDIR_UPPER_DIR_OFFSET;
    assign hit_wide  = cfg_wide && cfg_addr == UPDIR_LOWER_DIR_OFFSET && split_ff == UPDIR_IDLE;

    // Wide access: lower half goes out now, upper half lands next cycle so the two never coincide
    // Gated by the enable so a frozen block never hands a half access to the lower register
    assign lower_dir_wr    = clk_en && hit_wide && cfg_wr;
    assign lower_dir_rd    = clk_en && hit_wide && cfg_rd;
    assign lower_dir_wdata = cfg_wdata[15:0];

    assign upper_wr_now = (hit_upper && cfg_wr && !cfg_wide) || (split_ff == UPDIR_SECOND_HALF && split_wr_ff);
    assign upper_rd_now = (hit_upper && cfg_rd && !cfg_wide) || (split_ff == UPDIR_SECOND_HALF && !split_wr_ff);

    // ==========================================================
    // Split sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            split_ff       <= UPDIR_IDLE;
            split_wr_ff    <= 1'b0;
            split_wdata_ff <= UPDIR_DIR_RESET;
        end else if (clk_en) begin
            unique case (split_ff)
                UPDIR_IDLE: begin
                    if (hit_wide && (cfg_wr || cfg_rd)) begin
                        split_ff       <= UPDIR_SECOND_HALF;
                        split_wr_ff    <= cfg_wr;
                        split_wdata_ff <= cfg_wdata[31:16];
                    end
                end
                UPDIR_SECOND_HALF: begin
                    split_ff <= UPDIR_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Direction register
    always_comb begin
        nxt_upper_direction_register = upper_direction_register_ff;
        if (upper_wr_now) begin
            nxt_upper_direction_register = split_ff == UPDIR_SECOND_HALF ? split_wdata_ff : cfg_wdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            upper_direction_register_ff <= UPDIR_DIR_RESET;
        end else if (clk_en) begin
            upper_direction_register_ff <= nxt_upper_direction_register;
        end
    end

    // Read data is registered; wide reads return the upper half one cycle after the lower half
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_rdata       <= UPDIR_DIR_RESET;
            cfg_rdata_valid <= 1'b0;
        end else if (clk_en) begin
            cfg_rdata_valid <= upper_rd_now;
            if (upper_rd_now) begin
                cfg_rdata <= upper_direction_register_ff;
            end
        end
    end

    // ==========================================================
    // Pin steering: bit n of every vector belongs to pin 16+n
    genvar gi;
    generate
        for (gi = 0; gi < UPDIR_PIN_COUNT; gi++) begin : g_pin
            always_comb begin
                if (upper_function_select_register[gi]) begin
                    pin_oe[gi]  = func_oe[gi];
                    pin_out[gi] = func_out[gi];
                end else begin
                    pin_oe[gi]  = upper_direction_register_ff[gi];
                    pin_out[gi] = pin_data[gi];
                end
            end
        end
    endgenerate

endmodule // updir_upper_direction

// [updir_pkg.sv]
// Package of constants for the upper pin direction register block
//
// Notes on behaviour
// - Decode a 16-bit read/write direction register at offset c2c in configuration space.
// - Register bit n steers the direction of pin 16+n.
// - A direction bit of 0 means input, 1 means output.
// - Reset clears all sixteen bits, so every general-purpose pin is an input.
// - A set function-select bit makes the pin's direction bit ignored.
// - With function-select set, the interface function drives the pin and its enable.
// - A 32-bit access at offset c2a is split into two 16-bit accesses.
// - The lower register is accessed first, the upper one a cycle later.
// - A general-purpose output drives the level held in its data bit.
package updir_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] UPDIR_LOWER_DIR_OFFSET = 12'hc2a;
    localparam logic [11:0] UPDIR_UPPER_DIR_OFFSET = 12'hc2c;
    localparam int          UPDIR_PIN_COUNT        = 16;
    localparam logic [15:0] UPDIR_DIR_RESET        = 16'h0000;

    // ==========================================================
    // Split access sequencing
    typedef enum logic [0:0] {
        UPDIR_IDLE,
        UPDIR_SECOND_HALF
    } updir_split_type;

endpackage

// [updir_checker.sv]
// Port-level checker for the upper pin direction register
`timescale 1ns/1ps
// ==========
// Checks
module updir_checker
    import updir_pkg::*;
(
    // Access side
    input wire logic        clk, reset, clk_en, cfg_wr, cfg_rd, cfg_wide, cfg_rdata_valid, lower_dir_wr, lower_dir_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    // Read data, lower half write data and pin side
    input wire logic [15:0] cfg_rdata, lower_dir_wdata, upper_function_select_register, pin_data, func_out, func_oe,
    input wire logic [15:0] pin_out, pin_oe
);
    // Pins left to general-purpose use; only these show the direction bits
    wire [15:0] gp = ~upper_function_select_register;
    wire        nw = clk_en && !cfg_wide && cfg_addr == UPDIR_UPPER_DIR_OFFSET;
    wire        wd = clk_en && cfg_wide && cfg_addr == UPDIR_LOWER_DIR_OFFSET;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_FN_OE: assert property (((pin_oe ^ func_oe) & ~gp) == 16'h0) else $error("oe not from function");
    AST_FN_OUT: assert property (((pin_out ^ func_out) & ~gp) == 16'h0) else $error("out not from function");
    AST_GP_OUT: assert property (((pin_out ^ pin_data) & gp & pin_oe) == 16'h0) else $error("gp level");
    AST_WR16: assert property (nw && cfg_wr |=> ((pin_oe ^ $past(cfg_wdata[15:0])) & gp) == 16'h0)
        else $error("write lost");
    AST_RST: assert property ($fell(reset) |-> (pin_oe & gp) == 16'h0 && cfg_rdata == 16'h0) else $error("reset");
    AST_RD16: assert property (nw && cfg_rd |=> cfg_rdata_valid && ((cfg_rdata ^ pin_oe) & gp) == 16'h0
        ##1 !cfg_rdata_valid) else $error("read");
    AST_LOW: assert property (wd && (cfg_wr || cfg_rd) |-> lower_dir_wr == cfg_wr && lower_dir_rd == cfg_rd
        && lower_dir_wdata == cfg_wdata[15:0]) else $error("lower half");
    AST_HIGH: assert property (wd && cfg_wr |=> $stable(pin_oe & gp)
        ##1 ((pin_oe ^ $past(cfg_wdata[31:16], 2)) & gp) == 16'h0) else $error("upper half");
    AST_FREEZE: assert property (!clk_en |=> $stable(cfg_rdata) && $stable(cfg_rdata_valid)) else $error("frozen");
    AST_FREEZE_LOW: assert property (!clk_en |-> !lower_dir_wr && !lower_dir_rd) else $error("frozen lower");
endmodule // updir_checker

// [updir_upper_direction_tb.sv]
// Testbench for the upper pin direction register
`timescale 1ns/1ps
bind updir_upper_direction updir_checker updir_checker_inst (.*);
module updir_upper_direction_tb
    import updir_pkg::*;
;
    logic        clk = 0, reset = 1, en = 1, cfg_wr = 0, cfg_rd = 0, cfg_wide = 0, vld, lwr, lrd;
    logic [11:0] cfg_addr = 12'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [15:0] fsel = 16'h0, pdat = 16'h0, fout = 16'h0, foe = 16'h0, rdat, ldat, pout, poe;
    int          errors = 0, samples_checked = 0, cyc = 0;
    updir_upper_direction updir_upper_direction_inst (.clk(clk), .reset(reset), .clk_en(en), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wide(cfg_wide), .cfg_wdata(cfg_wdata), .cfg_rdata(rdat),
        .cfg_rdata_valid(vld), .lower_dir_wr(lwr), .lower_dir_rd(lrd), .lower_dir_wdata(ldat),
        .upper_function_select_register(fsel), .pin_data(pdat), .func_out(fout), .func_oe(foe),
        .pin_out(pout), .pin_oe(poe));
    initial forever #2.5 clk = ~clk;
    // A hang would otherwise never reach the verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            errors++;
            results();
        end
    end
    task results;
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // One-cycle strobe; returns just after the taking edge
    task acc(input logic [11:0] a, input logic w, r, wd, input logic [31:0] d);
        @(posedge clk); cfg_addr <= a; cfg_wr <= w; cfg_rd <= r; cfg_wide <= wd; cfg_wdata <= d;
        @(posedge clk); cfg_wr <= 0; cfg_rd <= 0; #1;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 0;
        acc(UPDIR_UPPER_DIR_OFFSET, 0, 1, 0, 0); chk("rdata", 16'h0, rdat); chk("oe", 16'h0, poe);
        acc(UPDIR_UPPER_DIR_OFFSET, 1, 0, 0, 32'h8001); chk("oe", 16'h8001, poe);
        acc(UPDIR_UPPER_DIR_OFFSET, 0, 1, 0, 0); chk("rdata", 16'h8001, rdat);
        acc(12'hc30, 1, 0, 0, 32'hffff); chk("oe", 16'h8001, poe);
        @(posedge clk); fsel <= 16'h00ff; foe <= 16'h0f0f; fout <= 16'h3333; pdat <= 16'hd555;
        #1 chk("oe", 16'h800f, poe);
        chk("out", 16'h8033, pout & 16'h80ff);
        acc(UPDIR_LOWER_DIR_OFFSET, 1, 0, 1, 32'h0f00_1234); chk("oe", 16'h800f, poe);
        @(posedge clk); #1 chk("oe", 16'h0f0f, poe);
        acc(UPDIR_LOWER_DIR_OFFSET, 0, 1, 1, 0); chk("valid", 16'h0, {15'h0, vld});
        @(posedge clk); #1 chk("rdata", 16'h0f00, rdat);
        @(posedge clk); en <= 0;
        acc(UPDIR_UPPER_DIR_OFFSET, 1, 0, 0, 32'h0); chk("oe", 16'h0f0f, poe);
        @(posedge clk); en <= 1;
        acc(UPDIR_UPPER_DIR_OFFSET, 0, 1, 0, 0); chk("rdata", 16'h0f00, rdat);
        results();
    end
endmodule // updir_upper_direction_tb
